// ### hw/vrss_pkg.sv
package vrss_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS       = 10;
  localparam int DELAY_STEP_NS       = 500000;
  localparam int DELAY_STEP_CYC      = DELAY_STEP_NS / CLK_PERIOD_NS;
  localparam int SS_STEP0_NS         = 62500;
  localparam int SS_BASE_CYC         = SS_STEP0_NS / CLK_PERIOD_NS;
  localparam int CHANGE_NS           = 250000;
  localparam int CHANGE_CYC          = CHANGE_NS / CLK_PERIOD_NS;
  localparam int PG_STATIC_NS        = 200;
  localparam int PG_STATIC_CYC       = PG_STATIC_NS / CLK_PERIOD_NS;
  localparam int CROWBAR_STATIC_NS   = 400;
  localparam int CROWBAR_STATIC_CYC  = CROWBAR_STATIC_NS / CLK_PERIOD_NS;
  localparam int DETECT_CYC          = 6;

  // Reference codes in 6.25 mV steps
  localparam logic [9:0] BOOT_CODE   = 10'h0a8;
  localparam logic [9:0] UV_BASE     = 10'h050;
  localparam logic [9:0] OV_BASE     = 10'h030;
  localparam logic [9:0] WIN_STEP    = 10'h008;

  // Setting reset values
  localparam logic [2:0] DELAY_CODE_RST = 3'h3;
  localparam logic [2:0] SLOPE_CODE_RST = 3'h2;
  localparam logic [2:0] UV_CODE_RST    = 3'h0;
  localparam logic [1:0] OV_CODE_RST    = 2'h0;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FIRST_DELAY,
    ST_PHASE_DETECT,
    ST_BOOT_RAMP,
    ST_BOOT_HOLD,
    ST_FINAL_RAMP,
    ST_MASK,
    ST_GOOD_BLANK,
    ST_RUN
  } vrss_state_t;

endpackage

// ### hw/vrss_sequencer.sv
// Function
// - Idle until enable high and lockout released, then one delay timer cycle.
// - First delay length comes from delay setting, default 2 ms.
// - First six clocks of soft-start keep PWM blanked for phase detection.
// - After detection, ramp the reference up to the 1.05 V boot voltage.
// - Hold boot voltage for a second delay timer cycle, same setting.
// - Processor settles code during hold; device samples it, ramps up or down.
// - After final ramp and masking interval, third timer cycle blanks power-good.
// - Undervoltage code 000 puts threshold 500 mV below reference.
// - Undervoltage code 111 puts threshold 150 mV below reference.
// - Overvoltage code 00 puts threshold 300 mV above reference.
// - Overvoltage code 11 puts threshold 150 mV above reference.
// - Crowbar trip follows overvoltage setting, 300 down to 150 mV.
// - Power-good qualification: timer in soft-start, 250 us changing, 200 ns static.
// - Crowbar waits 250 us while code changes, 400 ns when static.
// - Delay code 000..111 selects 0.5 to 4 ms, default 011.
// - Slope code 000..111 selects 0.1 to 1.5 V/ms, default 010.
// - Ramps move the reference in 6.25 mV steps to target.
// - First output low in detection; tied-high outputs go high impedance after.
`timescale 1ns/10ps
`default_nettype none
module vrss_sequencer
  import vrss_pkg::*;
#(
  parameter int DELAY_STEP  = DELAY_STEP_CYC,
  parameter int SS_BASE     = SS_BASE_CYC,
  parameter int CHANGE_WAIT = CHANGE_CYC
)
(
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic       enable_i,
  input  wire logic       supply_lockout_i,
  input  wire logic       cfg_wr_i,
  input  wire logic [2:0] delay_code_i,
  input  wire logic [2:0] slope_code_i,
  input  wire logic [2:0] power_good_low_threshold_i,
  input  wire logic [1:0] power_good_high_threshold_i,
  input  wire logic [7:0] cpu_voltage_code_i,
  input  wire logic [9:0] sense_code_i,
  input  wire logic [2:0] phase_tied_high_i,
  output logic [9:0]      ref_code_o,
  output logic [3:0]      pwm_run_o,
  output logic [2:0]      pwm_hiz_o,
  output logic            power_good_out_o,
  output logic            crowbar_o,
  output vrss_state_t     state_o
);
  vrss_state_t state_reg;
  logic [2:0]  delay_code_reg;
  logic [2:0]  slope_code_reg;
  logic [2:0]  uv_code_reg;
  logic [1:0]  ov_code_reg;
  logic [9:0]  ref_reg;
  logic [9:0]  target_reg;
  logic [2:0]  hiz_reg;
  logic [2:0]  detect_cnt_reg;
  logic [15:0] step_cnt_reg;
  logic [15:0] mask_cnt_reg;
  logic [15:0] uv_cnt_reg;
  logic [15:0] ov_cnt_reg;
  logic        pg_reg;
  logic        crowbar_reg;
  logic        tmr_load;
  logic        tmr_done;
  logic [23:0] delay_cyc;
  logic        abort;
  logic        ramping;
  logic        step_tick;
  logic        changing;
  logic        uv_fault;
  logic        ov_fault;
  logic [15:0] pg_qual;
  logic [15:0] cb_qual;

  function automatic logic [23:0] delay_cycles(input logic [2:0] code);
    delay_cycles = 24'((int'(code) + 1) * DELAY_STEP);
  endfunction

  function automatic logic [15:0] step_cycles(input logic [2:0] code);
    step_cycles = 16'(SS_BASE / (2 * int'(code) + 1));
  endfunction

  // Settings; a new delay code takes effect at the next timer load, slope at the next step, thresholds at once
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      delay_code_reg <= DELAY_CODE_RST;
      slope_code_reg <= SLOPE_CODE_RST;
      uv_code_reg    <= UV_CODE_RST;
      ov_code_reg    <= OV_CODE_RST;
    end
    else if (cfg_wr_i)
    begin
      delay_code_reg <= delay_code_i;
      slope_code_reg <= slope_code_i;
      uv_code_reg    <= power_good_low_threshold_i;
      ov_code_reg    <= power_good_high_threshold_i;
    end
  end

  assign abort     = !enable_i || supply_lockout_i;
  assign delay_cyc = delay_cycles(delay_code_reg);
  assign ramping   = (state_reg == ST_BOOT_RAMP) || (state_reg == ST_FINAL_RAMP)
                     || (state_reg == ST_RUN);
  assign step_tick = ramping && (step_cnt_reg == 16'h0) && (ref_reg != target_reg);
  assign changing  = (ref_reg != target_reg) || (mask_cnt_reg != 16'h0);

  // One shared delay timer serves first delay, boot hold and good blanking
  assign tmr_load = !abort && (((state_reg == ST_IDLE))
                    || (state_reg == ST_BOOT_RAMP && ref_reg == target_reg)
                    || (state_reg == ST_MASK && mask_cnt_reg == 16'h0));

  vrss_timer u_timer
  (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .load_i    (tmr_load),
    .count_i   (delay_cyc),
    .done_o    (tmr_done),
    .busy_o    ()
  );

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_reg <= ST_IDLE;
    else if (abort)
      state_reg <= ST_IDLE;
    else
    begin
      unique case (state_reg)
        ST_IDLE:         state_reg <= ST_FIRST_DELAY;
        ST_FIRST_DELAY:  if (tmr_done) state_reg <= ST_PHASE_DETECT;
        ST_PHASE_DETECT: if (detect_cnt_reg == 3'(DETECT_CYC - 1))
                           state_reg <= ST_BOOT_RAMP;
        ST_BOOT_RAMP:    if (ref_reg == target_reg) state_reg <= ST_BOOT_HOLD;
        ST_BOOT_HOLD:    if (tmr_done) state_reg <= ST_FINAL_RAMP;
        ST_FINAL_RAMP:   if (ref_reg == target_reg) state_reg <= ST_MASK;
        ST_MASK:         if (mask_cnt_reg == 16'h0) state_reg <= ST_GOOD_BLANK;
        ST_GOOD_BLANK:   if (tmr_done) state_reg <= ST_RUN;
        ST_RUN:          state_reg <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      detect_cnt_reg <= 3'h0;
    else if (state_reg == ST_PHASE_DETECT)
      detect_cnt_reg <= detect_cnt_reg + 3'h1;
    else
      detect_cnt_reg <= 3'h0;
  end

  // Tied-high phases are only known once detection has run its six clocks
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      hiz_reg <= 3'h0;
    else if (state_reg == ST_PHASE_DETECT && detect_cnt_reg == 3'(DETECT_CYC - 1))
      hiz_reg <= phase_tied_high_i;
  end

  // Target: boot voltage first, then the processor code sampled as the hold ends and again every cycle in run
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      target_reg <= 10'h0;
    else if (state_reg == ST_IDLE)
      target_reg <= BOOT_CODE;
    else if ((state_reg == ST_BOOT_HOLD && tmr_done) || state_reg == ST_RUN)
      target_reg <= {2'h0, cpu_voltage_code_i};
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      step_cnt_reg <= 16'h0;
    else if (!ramping || step_cnt_reg == 16'h0)
      step_cnt_reg <= step_cycles(slope_code_reg) - 16'h1;
    else
      step_cnt_reg <= step_cnt_reg - 16'h1;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      ref_reg <= 10'h0;
    else if (abort || state_reg == ST_IDLE)
      ref_reg <= 10'h0;
    else if (step_tick && ref_reg < target_reg)
      ref_reg <= ref_reg + 10'h1;
    else if (step_tick)
      ref_reg <= ref_reg - 10'h1;
  end

  // Masking reloads on every step, so it ends a full interval after the last one
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      mask_cnt_reg <= 16'h0;
    else if (state_reg == ST_FINAL_RAMP || (state_reg == ST_RUN && step_tick))
      mask_cnt_reg <= 16'(CHANGE_WAIT);
    else if (mask_cnt_reg != 16'h0)
      mask_cnt_reg <= mask_cnt_reg - 16'h1;
  end

  // Window in 6.25 mV steps: 8 steps per code is 50 mV
  assign uv_fault = ({1'b0, sense_code_i} + {1'b0, UV_BASE})
                    < ({1'b0, ref_reg} + {1'b0, 10'(uv_code_reg) * WIN_STEP});
  assign ov_fault = {1'b0, sense_code_i} > ({1'b0, ref_reg} + {1'b0, OV_BASE}
                    - {1'b0, 10'(ov_code_reg) * WIN_STEP});
  assign pg_qual  = changing ? 16'(CHANGE_WAIT) : 16'(PG_STATIC_CYC);
  assign cb_qual  = changing ? 16'(CHANGE_WAIT) : 16'(CROWBAR_STATIC_CYC);

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      uv_cnt_reg <= 16'h0;
      ov_cnt_reg <= 16'h0;
    end
    else
    begin
      uv_cnt_reg <= (uv_fault || ov_fault) ? uv_cnt_reg + {15'h0, uv_cnt_reg != 16'hffff}
                                           : 16'h0;
      ov_cnt_reg <= (ov_fault && ramping) ? ov_cnt_reg + {15'h0, ov_cnt_reg != 16'hffff}
                                          : 16'h0;
    end
  end

  // During soft-start power-good is simply held low until blanking ends
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      pg_reg <= 1'b0;
    else if (abort || state_reg != ST_RUN)
      pg_reg <= 1'b0;
    else
      pg_reg <= (uv_cnt_reg < pg_qual);
  end

  // Crowbar latches until the next abort; restart is the only way out
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      crowbar_reg <= 1'b0;
    else if (abort)
      crowbar_reg <= 1'b0;
    else if (ov_cnt_reg >= cb_qual)
      crowbar_reg <= 1'b1;
  end

  assign ref_code_o       = ref_reg;
  assign power_good_out_o = pg_reg;
  assign crowbar_o        = crowbar_reg;
  assign state_o          = state_reg;
  assign pwm_hiz_o        = hiz_reg;
  assign pwm_run_o        = (ramping && !crowbar_reg && !abort)
                            ? {~hiz_reg, 1'b1} : 4'h0;

  property p_start_delay;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (state_reg == ST_IDLE && !abort) |=> state_reg == ST_FIRST_DELAY;
  endproperty
  a_start_delay: assert property (p_start_delay) else $error("no first delay");

  property p_detect_len;
    @(posedge clk_sys_i) disable iff (!resetn_i || abort)
    $rose(state_reg == ST_PHASE_DETECT) |-> (pwm_run_o == 4'h0) [*6];
  endproperty
  a_detect_len: assert property (p_detect_len) else $error("detect not blanked");

  property p_boot_target;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    $rose(state_reg == ST_BOOT_HOLD) |-> ref_reg == BOOT_CODE;
  endproperty
  a_boot_target: assert property (p_boot_target) else $error("boot level wrong");

  property p_step_size;
    @(posedge clk_sys_i) disable iff (!resetn_i || abort || state_reg == ST_IDLE)
    ref_reg != $past(ref_reg) |-> (ref_reg - $past(ref_reg) == 10'h1)
                                  || ($past(ref_reg) - ref_reg == 10'h1);
  endproperty
  a_step_size: assert property (p_step_size) else $error("ramp step not one");

  property p_sample_code;
    @(posedge clk_sys_i) disable iff (!resetn_i || abort)
    (state_reg == ST_BOOT_HOLD && tmr_done) |=> target_reg == {2'h0, $past(cpu_voltage_code_i)};
  endproperty
  a_sample_code: assert property (p_sample_code) else $error("code not sampled");

  property p_pg_abort;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    abort |=> !power_good_out_o && !crowbar_o && state_reg == ST_IDLE;
  endproperty
  a_pg_abort: assert property (p_pg_abort) else $error("abort not honoured");

  property p_pg_only_run;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    power_good_out_o |-> $past(state_reg) == ST_RUN;
  endproperty
  a_pg_only_run: assert property (p_pg_only_run) else $error("good before run");

  property p_crowbar_off;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    crowbar_o |-> pwm_run_o == 4'h0;
  endproperty
  a_crowbar_off: assert property (p_crowbar_off) else $error("pwm on in crowbar");

  property p_hiz_masked;
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (pwm_run_o[3:1] & pwm_hiz_o) == 3'h0;
  endproperty
  a_hiz_masked: assert property (p_hiz_masked) else $error("tied phase driven");

  c_reach_run:  cover property (@(posedge clk_sys_i) $rose(state_reg == ST_RUN));
  c_crowbar:    cover property (@(posedge clk_sys_i) $rose(crowbar_o));
  c_pg_drop:    cover property (@(posedge clk_sys_i) $fell(power_good_out_o) && enable_i);
  c_ramp_down:  cover property (@(posedge clk_sys_i) state_reg == ST_FINAL_RAMP
                                && ref_reg > target_reg);
endmodule
`default_nettype wire

// ### hw/vrss_timer.sv
`timescale 1ns/10ps
`default_nettype none
module vrss_timer
(
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic        load_i,
  input  wire logic [23:0] count_i,
  output logic             done_o,
  output logic             busy_o
);
  logic [23:0] cnt_reg;

  // A load of N gives done exactly N cycles later; load wins over a running count
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cnt_reg <= 24'h0;
    else if (load_i)
      cnt_reg <= count_i;
    else if (cnt_reg != 24'h0)
      cnt_reg <= cnt_reg - 24'h1;
  end

  assign done_o = (cnt_reg == 24'h1) && !load_i;
  assign busy_o = (cnt_reg != 24'h0);
endmodule
`default_nettype wire

// ### sim/vrss_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module vrss_far_side
  import vrss_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic [9:0] ref_code_i,
  input  wire logic [7:0] target_i,
  input  wire logic [9:0] offset_i,
  output logic [7:0]      cpu_voltage_code_o,
  output logic [9:0]      sense_code_o
);
  logic settled_reg;

  // The processor only settles its code once the boot voltage is up; reset drives ref to 0
  always_ff @(posedge clk_sys_i)
  begin
    if (ref_code_i == BOOT_CODE)
      settled_reg <= 1'b1;
    else if (ref_code_i == 10'h000)
      settled_reg <= 1'b0;
  end

  // Unsettled code is deliberately wrong, so an early sample shows up
  assign cpu_voltage_code_o = settled_reg ? target_i : ~target_i;
  // Output follows the reference with a bench-chosen error, wrapping in 10 bits
  assign sense_code_o       = ref_code_i + offset_i;
endmodule
`default_nettype wire

// ### sim/vrss_testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import vrss_pkg::*;
  localparam int DSTEP = 20;
  logic        clk_sys_i;
  logic        resetn_i;
  logic        enable_i;
  logic        supply_lockout_i;
  logic        cfg_wr_i;
  logic [2:0]  delay_code_i;
  logic [2:0]  slope_code_i;
  logic [2:0]  uv_code;
  logic [1:0]  ov_code;
  logic [7:0]  cpu_code;
  logic [9:0]  sense_code;
  logic [2:0]  phase_tied_high_i;
  logic [9:0]  ref_code_o;
  logic [3:0]  pwm_run_o;
  logic [2:0]  pwm_hiz_o;
  logic        power_good_out_o;
  logic        crowbar_o;
  vrss_state_t state_o;
  logic [9:0]  offset;
  logic [9:0]  prev_ref;
  int          fails;
  int          n_compared;
  int          cycles;

  vrss_sequencer #(.DELAY_STEP(DSTEP), .SS_BASE(15), .CHANGE_WAIT(30)) dut (
    .clk_sys_i                   (clk_sys_i),
    .resetn_i                    (resetn_i),
    .enable_i                    (enable_i),
    .supply_lockout_i            (supply_lockout_i),
    .cfg_wr_i                    (cfg_wr_i),
    .delay_code_i                (delay_code_i),
    .slope_code_i                (slope_code_i),
    .power_good_low_threshold_i  (uv_code),
    .power_good_high_threshold_i (ov_code),
    .cpu_voltage_code_i          (cpu_code),
    .sense_code_i                (sense_code),
    .phase_tied_high_i           (phase_tied_high_i),
    .ref_code_o                  (ref_code_o),
    .pwm_run_o                   (pwm_run_o),
    .pwm_hiz_o                   (pwm_hiz_o),
    .power_good_out_o            (power_good_out_o),
    .crowbar_o                   (crowbar_o),
    .state_o                     (state_o)
  );

  vrss_far_side far (
    .clk_sys_i          (clk_sys_i),
    .ref_code_i         (ref_code_o),
    .target_i           (8'h90),
    .offset_i           (offset),
    .cpu_voltage_code_o (cpu_code),
    .sense_code_o       (sense_code)
  );

  initial
  begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic span(input vrss_state_t s, output int n);
    n = 0;
    while (state_o !== s && n < 5000)
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
  endtask

  task automatic cfg(input logic [2:0] d, s, u, input logic [1:0] o);
    @(posedge clk_sys_i);
    cfg_wr_i     <= 1'b1;
    delay_code_i <= d;
    slope_code_i <= s;
    uv_code      <= u;
    ov_code      <= o;
    @(posedge clk_sys_i);
    cfg_wr_i     <= 1'b0;
    #1;
  endtask

  task automatic startup(input int t);
    int n;
    @(posedge clk_sys_i);
    enable_i         <= 1'b1;
    supply_lockout_i <= 1'b0;
    tick(1);
    chk(state_o, ST_FIRST_DELAY);
    span(ST_PHASE_DETECT, n);
    chk(n, t);
    chk(pwm_run_o, 4'h0);
    span(ST_BOOT_RAMP, n);
    chk(n, 6);
    span(ST_BOOT_HOLD, n);
    chk(ref_code_o, BOOT_CODE);
    span(ST_FINAL_RAMP, n);
    chk(n, t);
    span(ST_MASK, n);
    chk(ref_code_o, 10'h090);
    span(ST_GOOD_BLANK, n);
    span(ST_RUN, n);
    chk(n, t);
    tick(2);
    chk(power_good_out_o, 1'b1);
    $display("test startup done");
  endtask

  // Power good must hold through 15 static fault cycles and answer by 25
  task automatic fault(input logic [9:0] off, input logic pg);
    @(posedge clk_sys_i);
    offset <= off;
    tick(15);
    chk(power_good_out_o, 1'b1);
    tick(10);
    chk(power_good_out_o, pg);
    chk(crowbar_o, 1'b0);
    @(posedge clk_sys_i);
    offset <= 10'h000;
    tick(3);
  endtask

  task automatic abort_check;
    tick(2);
    chk(state_o, ST_IDLE);
    chk(power_good_out_o, 1'b0);
    chk(crowbar_o, 1'b0);
    chk(pwm_run_o, 4'h0);
    $display("test abort done");
  endtask

  // Ramps may only move the reference one step at a time
  always @(posedge clk_sys_i)
  begin
    if (state_o == ST_BOOT_RAMP || state_o == ST_FINAL_RAMP)
      if (ref_code_o != prev_ref)
        chk(ref_code_o > prev_ref ? ref_code_o - prev_ref : prev_ref - ref_code_o, 1);
    prev_ref = ref_code_o;
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_of_test();
    end
  end

  initial
  begin
    resetn_i = 1'b0;
    enable_i = 1'b0;
    supply_lockout_i = 1'b1;
    cfg_wr_i = 1'b0;
    delay_code_i = 3'h0;
    slope_code_i = 3'h0;
    uv_code = 3'h0;
    ov_code = 2'h0;
    phase_tied_high_i = 3'h0;
    offset = 10'h000;
    prev_ref = 10'h000;
    fails = 0;
    n_compared = 0;
    cycles = 0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk(state_o, ST_IDLE);
    chk(power_good_out_o, 1'b0);
    @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    startup(4 * DSTEP);
    chk(pwm_run_o, 4'hf);
    fault(10'h3b1, 1'b1);
    fault(10'h3af, 1'b0);
    fault(10'h02f, 1'b1);
    fault(10'h031, 1'b0);
    @(posedge clk_sys_i);
    supply_lockout_i <= 1'b1;
    abort_check();
    cfg(3'h0, 3'h7, 3'h7, 2'h3);
    @(posedge clk_sys_i);
    phase_tied_high_i <= 3'h4;
    startup(DSTEP);
    chk(pwm_hiz_o, 3'h4);
    chk(pwm_run_o, 4'h7);
    fault(10'h3e9, 1'b1);
    fault(10'h3e7, 1'b0);
    fault(10'h017, 1'b1);
    fault(10'h019, 1'b0);
    @(posedge clk_sys_i);
    offset <= 10'h019;
    tick(45);
    chk(crowbar_o, 1'b1);
    chk(pwm_run_o, 4'h0);
    $display("test crowbar done");
    @(posedge clk_sys_i);
    enable_i <= 1'b0;
    offset   <= 10'h000;
    abort_check();
    end_of_test();
  end
endmodule
`default_nettype wire
